// File: free_running_and_interval_timer.sv
// What this block does
// - a 16-bit counter counts up forever at the 4 MHz timer rate
// - timer runs from a one-cycle tick enable on pclk; no crossing to the bus side is needed
// - reading the counter low byte samples all 16 bits and holds the high byte
// - reading the counter high byte returns the held byte, not the live count
// - a periodic interrupt is raised every 1024 microseconds
// - a separate interrupt is raised on every 16-bit counter wrap
// - a counter low write is held; the high write loads all 16 bits
// - counter bytes are read/write at indices 0x20 and 0x21, reset zero
// - reading interval count low byte captures its upper nibble for atomic read
// - interval high returns captured nibble in bits 3:0, upper bits zero
// - interval count registers at 0x26 and 0x27 are read-only, reset zero
// - 12-bit reload at 0x28 and 0x29 low nibble, read/write, reset zero
// - counter wrap is its own interrupt source, apart from the others
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module free_running_and_interval_timer
  import timer_pkg::*;
#(
  parameter int TICK_DIVIDE = timer_pkg::TICK_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupts
  output timer_pkg::timer_events_s event_pulse,
  output logic irq
);
  import timer_pkg::*;

  localparam int DIV_W = $clog2(TICK_DIVIDE + 1);

  // timer side: tick divider and the two counters
  logic [DIV_W-1:0] div_reg;
  logic div_last;
  logic tick_reg;
  logic [FREE_W-1:0] free_count_reg;
  logic [INTERVAL_W-1:0] interval_count_reg;
  logic [INTERVAL_W-1:0] reload_reg;

  // staging and holding bytes that make multi-byte access atomic
  logic [BYTE_W-1:0] free_high_hold_reg;
  logic [BYTE_W-1:0] free_low_pending_reg;
  logic [NIBBLE_W-1:0] interval_high_hold_reg;
  logic [BYTE_W-1:0] reload_low_pending_reg;

  // interrupt state and the pulse flops toward the interrupt controller
  logic [EVENT_W-1:0] status_reg;
  logic [EVENT_W-1:0] mask_reg;
  logic [EVENT_W-1:0] pending;
  logic irq_reg;
  logic periodic_pulse_reg;
  logic wrap_pulse_reg;
  logic interval_pulse_reg;

  // bus answer flops
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // bus-side decode of the current transfer
  logic [7:0] idx;
  logic aligned;
  logic access;
  logic first_access;
  logic commit;
  logic wr;
  logic rd_sample;
  logic mapped;
  logic [31:0] rd_value;

  // one select per register that has a side effect
  logic sel_free_low;
  logic sel_free_high;
  logic sel_count_low;
  logic sel_reload_low;
  logic sel_reload_high;
  logic sel_status;
  logic sel_mask;

  // write strobes, each high only in the cycle a write lands
  logic wr_free_low;
  logic free_load;
  logic wr_reload_low;
  logic wr_reload_high;
  logic wr_status;
  logic wr_mask;

  // read captures, high in the first access cycle of a mapped read
  logic rd_free_low;
  logic rd_count_low;

  // timer-side conditions seen at a tick
  logic periodic_hit;
  logic wrap_hit;
  logic interval_zero;
  logic [EVENT_W-1:0] ev_now;

  assign idx = paddr[ADDR_LSB +: 8];
  assign aligned = (paddr[ADDR_LSB-1:0] == '0);
  assign access = psel & penable;
  // the access cycle before pready samples read data, read side effects and the error flag; write data is taken at commit
  assign first_access = access & ~pready_reg;
  // data and side effects are sampled in the first access cycle
  assign rd_sample = first_access & ~pwrite;
  // a write lands at the edge where the master sees pready
  assign commit = access & pready_reg;
  assign wr = commit & pwrite & ~pslverr_reg;

  // register selects; alignment is checked once, in mapped, and a
  // refused transfer never reaches the strobes below
  assign sel_free_low = (idx == FREE_COUNT_LOW_IDX);
  assign sel_free_high = (idx == FREE_COUNT_HIGH_IDX);
  assign sel_count_low = (idx == INTERVAL_COUNT_LOW_IDX);
  assign sel_reload_low = (idx == INTERVAL_RELOAD_LOW_IDX);
  assign sel_reload_high = (idx == INTERVAL_RELOAD_HIGH_IDX);
  assign sel_status = (idx == IRQ_STATUS_IDX);
  assign sel_mask = (idx == IRQ_MASK_IDX);

  // write strobes; wr already excludes refused transfers
  assign wr_free_low = wr & sel_free_low;
  assign free_load = wr & sel_free_high;
  assign wr_reload_low = wr & sel_reload_low;
  assign wr_reload_high = wr & sel_reload_high;
  assign wr_status = wr & sel_status;
  assign wr_mask = wr & sel_mask;

  // read captures; a refused read must not disturb the holding registers
  assign rd_free_low = rd_sample & mapped & sel_free_low;
  assign rd_count_low = rd_sample & mapped & sel_count_low;

  // address decode; the two address bits below the index must be zero
  always_comb begin
    mapped = 1'b0;
    unique case (idx)
      FREE_COUNT_LOW_IDX, FREE_COUNT_HIGH_IDX,
      INTERVAL_COUNT_LOW_IDX, INTERVAL_COUNT_HIGH_IDX,
      INTERVAL_RELOAD_LOW_IDX, INTERVAL_RELOAD_HIGH_IDX,
      IRQ_STATUS_IDX, IRQ_MASK_IDX: mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end

  // last count of the divider
  assign div_last = (div_reg == DIV_W'(TICK_DIVIDE - 1));

  // tick divider: the timer rate is a one-cycle enable, so the whole block
  // shares pclk and no crossing is needed between timer and bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_last) begin
      div_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + DIV_W'(1);
      tick_reg <= 1'b0;
    end
  end

  // free-running counter; a high-byte write loads all 16 bits at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_count_reg <= FREE_RESET;
    end else if (free_load) begin
      free_count_reg <= {pwdata[BYTE_W-1:0], free_low_pending_reg};
    end else if (tick_reg) begin
      free_count_reg <= free_count_reg + FREE_W'(1);
    end
  end

  // low-byte write waits here until the high byte arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_low_pending_reg <= BYTE_RESET;
    end else if (wr_free_low) begin
      free_low_pending_reg <= pwdata[BYTE_W-1:0];
    end
  end

  // counter high byte is frozen by the low-byte read, so a later high read
  // cannot tear even if the count carries in between
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_high_hold_reg <= BYTE_RESET;
    end else if (rd_free_low) begin
      free_high_hold_reg <= free_count_reg[FREE_W-1:BYTE_W];
    end
  end

  // interval upper nibble is frozen the same way by its low-byte read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_high_hold_reg <= '0;
    end else if (rd_count_low) begin
      interval_high_hold_reg <= interval_count_reg[INTERVAL_W-1:BYTE_W];
    end
  end

  // reload low byte is staged; alone it changes nothing in the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_low_pending_reg <= BYTE_RESET;
    end else if (wr_reload_low) begin
      reload_low_pending_reg <= pwdata[BYTE_W-1:0];
    end
  end

  // the nibble write commits all 12 bits; the count picks them up at zero,
  // so a half-written reload can never be loaded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_reg <= INTERVAL_RESET;
    end else if (wr_reload_high) begin
      reload_reg <= {pwdata[NIBBLE_W-1:0], reload_low_pending_reg};
    end
  end

  // terminal count of the interval timer
  assign interval_zero = (interval_count_reg == '0);

  // interval down-counter, reloads at terminal count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_count_reg <= INTERVAL_RESET;
    end else if (tick_reg) begin
      if (interval_zero) begin
        interval_count_reg <= reload_reg;
      end else begin
        interval_count_reg <= interval_count_reg - INTERVAL_W'(1);
      end
    end
  end

  // wrap and periodic points of the free count; a load in the same cycle
  // wins, so a freshly written value never raises a stale event
  assign periodic_hit = (free_count_reg[PERIODIC_W-1:0] == {PERIODIC_W{1'b1}});
  assign wrap_hit = (free_count_reg == {FREE_W{1'b1}});

  // events on the tick; the periodic one falls on every 4096th tick
  always_comb begin
    ev_now = EVENT_RESET;
    ev_now[EV_PERIODIC] = tick_reg && !free_load && periodic_hit;
    ev_now[EV_WRAP] = tick_reg && !free_load && wrap_hit;
    ev_now[EV_INTERVAL] = tick_reg && interval_zero;
  end

  // periodic pulse: one flop per source keeps every pulse one cycle wide,
  // provided ticks are at least two clocks apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_pulse_reg <= 1'b0;
    end else begin
      periodic_pulse_reg <= ev_now[EV_PERIODIC];
    end
  end

  // wrap pulse, a source of its own apart from periodic and interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_pulse_reg <= 1'b0;
    end else begin
      wrap_pulse_reg <= ev_now[EV_WRAP];
    end
  end

  // interval pulse; with a zero reload it fires on every tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_pulse_reg <= 1'b0;
    end else begin
      interval_pulse_reg <= ev_now[EV_INTERVAL];
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= EVENT_RESET;
    end else begin
      if (wr_status) begin
        status_reg <= (status_reg & ~pwdata[EVENT_W-1:0]) | ev_now;
      end else begin
        status_reg <= status_reg | ev_now;
      end
    end
  end

  // mask register, same layout as status; masking never clears status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= EVENT_RESET;
    end else if (wr_mask) begin
      mask_reg <= pwdata[EVENT_W-1:0];
    end
  end

  // unmasked sources that are waiting
  assign pending = status_reg & mask_reg;

  // level interrupt from a flop: glitch-free, at the cost of one cycle's lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |pending;
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    rd_value = WORD_ZERO;
    unique case (idx)
      FREE_COUNT_LOW_IDX: rd_value[BYTE_W-1:0] = free_count_reg[BYTE_W-1:0];
      FREE_COUNT_HIGH_IDX: rd_value[BYTE_W-1:0] = free_high_hold_reg;
      INTERVAL_COUNT_LOW_IDX: rd_value[BYTE_W-1:0] = interval_count_reg[BYTE_W-1:0];
      INTERVAL_COUNT_HIGH_IDX: rd_value[NIBBLE_W-1:0] = interval_high_hold_reg;
      INTERVAL_RELOAD_LOW_IDX: rd_value[BYTE_W-1:0] = reload_low_pending_reg;
      INTERVAL_RELOAD_HIGH_IDX: rd_value[NIBBLE_W-1:0] = reload_reg[INTERVAL_W-1:BYTE_W];
      IRQ_STATUS_IDX: rd_value[EVENT_W-1:0] = status_reg;
      IRQ_MASK_IDX: rd_value[EVENT_W-1:0] = mask_reg;
      default: rd_value = WORD_ZERO;
    endcase
  end

  // one wait state so read data comes from a flop; pready is one cycle wide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else if (first_access) begin
      pready_reg <= 1'b1;
    end else begin
      pready_reg <= 1'b0;
    end
  end

  // error flag rides with pready for unmapped or misaligned addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else if (first_access) begin
      pslverr_reg <= ~mapped;
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  // read data holds until the next access; writes and refusals read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= WORD_ZERO;
    end else if (first_access) begin
      prdata_reg <= (mapped && !pwrite) ? rd_value : WORD_ZERO;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign event_pulse = '{interval: interval_pulse_reg, wrap: wrap_pulse_reg,
                         periodic: periodic_pulse_reg};
  assign irq = irq_reg;
endmodule : free_running_and_interval_timer
`default_nettype wire

// File: timer_pkg.sv
`default_nettype none
package timer_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] FREE_COUNT_LOW_IDX = 8'h20;
  localparam logic [7:0] FREE_COUNT_HIGH_IDX = 8'h21;
  localparam logic [7:0] INTERVAL_COUNT_LOW_IDX = 8'h26;
  localparam logic [7:0] INTERVAL_COUNT_HIGH_IDX = 8'h27;
  localparam logic [7:0] INTERVAL_RELOAD_LOW_IDX = 8'h28;
  localparam logic [7:0] INTERVAL_RELOAD_HIGH_IDX = 8'h29;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h30;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h31;
  localparam int ADDR_W = 10;
  localparam int ADDR_LSB = 2;

  // widths
  localparam int FREE_W = 16;
  localparam int INTERVAL_W = 12;
  localparam int BYTE_W = 8;
  localparam int NIBBLE_W = 4;
  localparam int EVENT_W = 3;

  // interrupt status / mask bit positions
  localparam int EV_PERIODIC = 0;
  localparam int EV_WRAP = 1;
  localparam int EV_INTERVAL = 2;

  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] FREE_RESET = 16'h0000;
  localparam logic [11:0] INTERVAL_RESET = 12'h000;
  localparam logic [2:0] EVENT_RESET = 3'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // timing: timer tick rate derived from the bus clock
  localparam int PCLK_HZ = 20_000_000;
  localparam int TIMER_HZ = 4_000_000;
  localparam int TICK_DIV = PCLK_HZ / TIMER_HZ;
  localparam int PERIODIC_US = 1024;
  localparam int PERIODIC_TICKS = PERIODIC_US * (TIMER_HZ / 1_000_000);
  localparam int PERIODIC_W = $clog2(PERIODIC_TICKS);

  // one-cycle event pulses toward the interrupt controller
  typedef struct packed {
    logic interval;
    logic wrap;
    logic periodic;
  } timer_events_s;
endpackage : timer_pkg
`default_nettype wire

// File: apb_cpu.sv
`timescale 1ns/100ps
`default_nettype none
module apb_cpu (
  // bus clock
  input wire logic pclk,
  // request, idle from time zero
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [9:0] paddr = 10'h000,
  output logic [31:0] pwdata = 32'h0000_0000,
  // answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // one transfer; callers send low byte before high byte
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released data must not look still valid
  endtask : xfer
endmodule : apb_cpu
`default_nettype wire

// File: timer_checker.sv
`timescale 1ns/100ps
`default_nettype none
module timer_checker
  import timer_pkg::*;
#(parameter int TICK_DIVIDE = 5) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // interrupts
  input wire timer_pkg::timer_events_s event_pulse,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // own map decode, kept apart from the design so a wrong table shows
  logic acc;
  logic hit;
  assign acc = psel && penable && pready;
  assign hit = paddr[1:0] == 2'b00 && paddr[9:2] inside {8'h20, 8'h21, [8'h26:8'h29], 8'h30, 8'h31};
  chk_ready_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_map_error: assert property (acc |-> pslverr == !hit)
    else $error("pslverr wrong for address");
  chk_read_byte: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data above the byte");
  chk_nibble_zero: assert property (
    acc && !pwrite && paddr[9:2] inside {8'h27, 8'h29} |-> prdata[7:4] == 4'h0)
    else $error("reserved bits not zero");
  chk_event_pulse: assert property (
    |event_pulse |=> (event_pulse & $past(event_pulse)) == 3'h0)
    else $error("event longer than one cycle");
  chk_wrap_periodic: assert property (event_pulse.wrap |-> event_pulse.periodic)
    else $error("wrap without periodic event");
  chk_mask_off: assert property (
    acc && pwrite && hit && paddr[9:2] == IRQ_MASK_IDX && pwdata[2:0] == 3'h0 |-> ##[1:3] !irq)
    else $error("irq stays with all masked");
  // main scenarios reached
  cover property (event_pulse.wrap);
  cover property (acc && pslverr);
  cover property ($rose(irq));
endmodule : timer_checker
bind free_running_and_interval_timer timer_checker #(.TICK_DIVIDE(TICK_DIVIDE)) u_timer_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .event_pulse, .irq);
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import timer_pkg::*;
  localparam int DIV = 2; // fastest rate that keeps event pulses one cycle wide
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, e;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, r, lo, seed;
  timer_events_s event_pulse;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int q[$];
  always #25 pclk = ~pclk;
  // device and processor-side bus model
  free_running_and_interval_timer #(.TICK_DIVIDE(DIV)) u_free_running_and_interval_timer (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .event_pulse, .irq);
  apb_cpu u_apb_cpu (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    u_apb_cpu.xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [9:0] a);
    u_apb_cpu.xfer(1'b0, a, 32'h0000_0000, r, e);
  endtask : rd
  // clocks from one pulse of an event bit to the next
  task automatic gap(input int b, output int n);
    n = 0;
    do @(posedge pclk); while (event_pulse[b] !== 1'b1);
    do begin
      @(posedge pclk);
      n++;
    end while (event_pulse[b] !== 1'b1);
  endtask : gap
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // hang guard, about twice what the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    int n;
    seed = 32'd10433;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, ignored write to read-only count, refused addresses
    wr(10'h098, 32'h0000_00FF);
    q = '{'h098, 'h09C, 'h0A0, 'h0A4, 'h0C4};
    foreach (q[i]) begin
      rd(q[i][9:0]);
      cmp(r, 32'h0000_0000);
    end
    q = '{'h3FC, 'h081};
    foreach (q[i]) begin
      rd(q[i][9:0]);
      cmp({r[30:0], e}, 32'h0000_0001);
    end
    $display("test registers done");
    // random reload seen through the interval event spacing
    seed = xs(seed);
    wr(10'h0A0, seed);
    rd(10'h0A0);
    cmp(r, {24'h00_0000, seed[7:0]});
    wr(10'h0A4, 32'h0000_00F1);
    rd(10'h0A4);
    cmp(r, 32'h0000_0001);
    gap(EV_INTERVAL, n);
    gap(EV_INTERVAL, n);
    cmp(n, (257 + seed[7:0]) * DIV);
    $display("test interval done");
    // staged load, then a held high byte long after the low read
    wr(10'h080, 32'h0000_00F0);
    wr(10'h084, 32'h0000_0012);
    rd(10'h080);
    lo = r;
    repeat (300) @(posedge pclk);
    rd(10'h084);
    cmp(r, 32'h0000_0012);
    cmp(lo & 32'h0000_00F0, 32'h0000_00F0);
    $display("test counter done");
    // wrap event, status, mask and level interrupt
    wr(10'h080, 32'h0000_00F0);
    wr(10'h084, 32'h0000_00FF);
    do @(posedge pclk); while (event_pulse.wrap !== 1'b1);
    rd(10'h0C0);
    cmp(r & 32'h0000_0003, 32'h0000_0003);
    wr(10'h0C4, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    cmp(irq, 1'b1);
    wr(10'h0C0, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    cmp(irq, 1'b0);
    wr(10'h0C4, 32'h0000_0000);
    gap(EV_PERIODIC, n);
    cmp(n, PERIODIC_TICKS * DIV);
    $display("test events done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
